// >>> core/spi_fram_map.svh
// Purpose: Constants for the serial nonvolatile memory command slave
// Assumes: Included by the package and by the main module
// Notes:   Offsets, field positions, reset values and opcodes only
`ifndef SPI_FRAM_MAP_SVH
`define SPI_FRAM_MAP_SVH

`define OP_LATCH_SET     8'h06
`define OP_LATCH_CLEAR   8'h04
`define OP_STATUS_READ   8'h05
`define OP_STATUS_WRITE  8'h01
`define OP_MEM_READ      8'h03
`define OP_MEM_WRITE     8'h02

`define ADDR_W           11
`define ADDR_LAST        11'h7FF
`define ADDR_FIRST       11'h000
`define QUARTER_BASE     11'h600
`define HALF_BASE        11'h400

`define SR_PIN_PROTECT   7
`define SR_BLOCK_HI      3
`define SR_BLOCK_LO      2
`define SR_LATCH         1
`define NV_RESET         3'h0

`define BYTE_LAST_BIT    4'h7
`define ADDR_LAST_BIT    4'hF
`define SYNC_W           5

`endif

// >>> core/spi_fram_pkg.sv
// Purpose: Types and shared functions for the command slave
// Assumes: spi_fram_map.svh holds every number
// Notes:   blocked serves both the logic and its assertions; status_byte serves only the logic
`include "spi_fram_map.svh"

package spi_fram_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_WR_DATA,
    ST_RD_DATA,
    ST_SR_RD,
    ST_SR_WR,
    ST_IGNORE
  } slave_state_t;

  // True when the block-protect pair covers this address
  function automatic logic blocked(input logic [1:0] bp, input logic [`ADDR_W-1:0] addr);
    case (bp)
      2'h1:    blocked = (addr >= `QUARTER_BASE);
      2'h2:    blocked = (addr >= `HALF_BASE);
      2'h3:    blocked = 1'b1;
      default: blocked = 1'b0;
    endcase
  endfunction : blocked

  // Nonvolatile bits are {pin protect, block hi, block lo}
  function automatic logic [7:0] status_byte(input logic [2:0] nv, input logic write_latch_flag);
    status_byte = 8'h00;
    status_byte[`SR_PIN_PROTECT] = nv[2];
    status_byte[`SR_BLOCK_HI] = nv[1];
    status_byte[`SR_BLOCK_LO] = nv[0];
    status_byte[`SR_LATCH] = write_latch_flag;
  endfunction : status_byte

endpackage : spi_fram_pkg

// >>> core/pin_sync.sv
// Purpose: Two-flop synchroniser for a group of pins
// Assumes: Pins are unrelated levels; no bus coherency is needed
// Notes:   The first stage feeds only the second stage
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] rst_val,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= rst_val;
      q      <= rst_val;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : pin_sync

// >>> core/spi_fram_command_slave.sv
// Purpose: Serial slave of a 2,048 x 8 nonvolatile memory
// Assumes: clk well above twice the serial clock; storage sits outside
// Notes:   Serial pins are sampled on clk; all edges come from the samples
//
// What this block does
// - Transfers are bytes, most significant bit first.
// - Input sampled on clock rise; output changes on clock fall.
// - Only clock modes 0 and 3; capture always on rising edges.
// - Six opcodes decoded; 03h reads memory, 02h writes memory.
// - Opcode 06h sets the write latch; status bit 1 shows it.
// - Opcode 04h clears the write latch, blocking all writes.
// - Write latch is clear after reset.
// - Finishing a memory or status write clears the write latch.
// - Status writes ignore the latch bit of the data byte; the latch clears afterwards.
// - Opcode 05h returns one status byte.
// - Opcode 01h writes status if latch set and not pin-protected.
// - Status: bit 7 pin protect, bits 3-2 block protect, bit 1 latch.
// - Block pair: 00 none, 01 600h-7FFh, 10 400h-7FFh, 11 all.
// - Pin protect enable with protect pin low rejects status writes.
// - Protect pin never blocks memory array writes.
// - Memory write needs latch set and address outside protected range.
// - Two address bytes follow; only the low 11 bits are used.
// - Address advances per byte, wrapping 7FFh to 000h.
// - Each data byte is stored at its eighth bit, no busy time.
// - Chip select rising ends a memory read or write.
// - During read data the serial input is ignored.
// - Hold low pauses; clock edges ignored until hold returns high.
// - One opcode per select; first byte after select is the opcode.
// - Output driven only while returning read data.
`include "spi_fram_map.svh"

module spi_fram_command_slave (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                sck,
  input  wire logic                cs_n,
  input  wire logic                si,
  input  wire logic                hold_n,
  input  wire logic                wp_n,
  output logic                     so,
  output logic                     so_oe,
  output logic [`ADDR_W-1:0]       mem_addr,
  output logic [7:0]               mem_wdata,
  output logic                     mem_wr,
  output logic                     mem_rd,
  input  wire logic [7:0]          mem_rdata,
  output logic [7:0]               write_protect_status
);

  logic [`SYNC_W-1:0]       pins_s;
  logic                     sck_s;
  logic                     cs_n_s;
  logic                     si_s;
  logic                     hold_n_s;
  logic                     wp_n_s;

  pin_sync #(
    .W (`SYNC_W)
  ) u_sync (
    .clk     (clk),
    .srst    (srst),
    .rst_val (5'h1E),
    .d       ({sck, cs_n, si, hold_n, wp_n}),
    .q       (pins_s)
  );

  assign sck_s    = pins_s[4];
  assign cs_n_s   = pins_s[3];
  assign si_s     = pins_s[2];
  assign hold_n_s = pins_s[1];
  assign wp_n_s   = pins_s[0];

  spi_fram_pkg::slave_state_t st_q, st_d;
  logic                     sck_prev_q;
  logic [3:0]               cnt_q, cnt_d;
  logic [7:0]               in_q, in_d;
  logic [7:0]               cmd_q, cmd_d;
  logic [`ADDR_W-1:0]       addr_q, addr_d;
  logic                     wel_q, wel_d;
  logic [2:0]               nv_q, nv_d;
  logic [7:0]               rdbuf_q, rdbuf_d;
  logic [7:0]               sh_q, sh_d;
  logic                     drive_q, drive_d;
  logic                     rd_wait_q;
  logic                     so_d, so_oe_d;
  logic [`ADDR_W-1:0]       mem_addr_d;
  logic [7:0]               mem_wdata_d;
  logic                     mem_wr_d, mem_rd_d;
  logic                     rise, fall, end_frame;
  logic [7:0]               byte_in;
  logic                     byte_done;
  logic                     sr_locked;

  // Edges are ignored while paused; hold may only move with the clock low
  assign rise      = sck_s & ~sck_prev_q & hold_n_s & ~cs_n_s;
  assign fall      = ~sck_s & sck_prev_q & hold_n_s & ~cs_n_s;
  assign end_frame = cs_n_s & hold_n_s;
  assign byte_in   = {in_q[6:0], si_s};
  assign byte_done = rise & (cnt_q == `BYTE_LAST_BIT);
  assign sr_locked = nv_q[2] & ~wp_n_s;

  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    in_d        = in_q;
    cmd_d       = cmd_q;
    addr_d      = addr_q;
    wel_d       = wel_q;
    nv_d        = nv_q;
    rdbuf_d     = rd_wait_q ? mem_rdata : rdbuf_q;
    sh_d        = sh_q;
    drive_d     = drive_q;
    so_d        = so;
    mem_addr_d  = mem_addr;
    mem_wdata_d = mem_wdata;
    mem_wr_d    = 1'b0;
    mem_rd_d    = 1'b0;
    if (end_frame) begin
      // A write op ends here, so the latch must not outlive it
      if ((cmd_q == `OP_MEM_WRITE) && ((st_q == spi_fram_pkg::ST_ADDR) ||
          (st_q == spi_fram_pkg::ST_WR_DATA))) begin
        wel_d = 1'b0;
      end
      st_d    = spi_fram_pkg::ST_IDLE;
      cnt_d   = 4'h0;
      drive_d = 1'b0;
    end else if (st_q == spi_fram_pkg::ST_IDLE) begin
      if (!cs_n_s) begin
        st_d  = spi_fram_pkg::ST_OPCODE;
        cnt_d = 4'h0;
      end
    end else if (rise) begin
      in_d  = byte_in;
      cnt_d = cnt_q + 4'h1;
      case (st_q)
        spi_fram_pkg::ST_OPCODE: begin
          if (byte_done) begin
            cmd_d = byte_in;
            cnt_d = 4'h0;
            case (byte_in)
              `OP_LATCH_SET: begin
                wel_d = 1'b1;
                st_d  = spi_fram_pkg::ST_IGNORE;
              end
              `OP_LATCH_CLEAR: begin
                wel_d = 1'b0;
                st_d  = spi_fram_pkg::ST_IGNORE;
              end
              `OP_STATUS_READ: begin
                rdbuf_d = spi_fram_pkg::status_byte(nv_q, wel_q);
                st_d    = spi_fram_pkg::ST_SR_RD;
              end
              `OP_STATUS_WRITE: begin
                st_d = spi_fram_pkg::ST_SR_WR;
              end
              `OP_MEM_READ, `OP_MEM_WRITE: begin
                st_d = spi_fram_pkg::ST_ADDR;
              end
              default: begin
                st_d = spi_fram_pkg::ST_IGNORE;
              end
            endcase
          end
        end
        spi_fram_pkg::ST_ADDR: begin
          // Shifting through 11 bits drops the upper five on its own
          addr_d = {addr_q[`ADDR_W-2:0], si_s};
          if (cnt_q == `ADDR_LAST_BIT) begin
            cnt_d = 4'h0;
            if (cmd_q == `OP_MEM_READ) begin
              mem_rd_d   = 1'b1;
              mem_addr_d = {addr_q[`ADDR_W-2:0], si_s};
              addr_d     = {addr_q[`ADDR_W-2:0], si_s} + `ADDR_W'(1);
              st_d       = spi_fram_pkg::ST_RD_DATA;
            end else begin
              st_d = spi_fram_pkg::ST_WR_DATA;
            end
          end
        end
        spi_fram_pkg::ST_WR_DATA: begin
          if (byte_done) begin
            cnt_d = 4'h0;
            // Protect pin plays no part here
            if (wel_q && !spi_fram_pkg::blocked(nv_q[1:0], addr_q)) begin
              mem_wr_d    = 1'b1;
              mem_addr_d  = addr_q;
              mem_wdata_d = byte_in;
            end
            addr_d = addr_q + `ADDR_W'(1);
          end
        end
        spi_fram_pkg::ST_RD_DATA: begin
          // Input bits are shifted but never used
          if (byte_done) begin
            cnt_d      = 4'h0;
            mem_rd_d   = 1'b1;
            mem_addr_d = addr_q;
            addr_d     = addr_q + `ADDR_W'(1);
          end
        end
        spi_fram_pkg::ST_SR_RD: begin
          if (byte_done) begin
            cnt_d   = 4'h0;
            drive_d = 1'b0;
            st_d    = spi_fram_pkg::ST_IGNORE;
          end
        end
        spi_fram_pkg::ST_SR_WR: begin
          if (byte_done) begin
            cnt_d = 4'h0;
            if (wel_q && !sr_locked) begin
              // Latch flag position of the byte is dropped
              nv_d = {byte_in[`SR_PIN_PROTECT], byte_in[`SR_BLOCK_HI], byte_in[`SR_BLOCK_LO]};
            end
            wel_d = 1'b0;
            st_d  = spi_fram_pkg::ST_IGNORE;
          end
        end
        default: begin
          cnt_d = 4'h0;
        end
      endcase
    end else if (fall && ((st_q == spi_fram_pkg::ST_RD_DATA) || (st_q == spi_fram_pkg::ST_SR_RD))) begin
      drive_d = 1'b1;
      if (cnt_q == 4'h0) begin
        so_d = rdbuf_q[7];
        sh_d = {rdbuf_q[6:0], 1'b0};
      end else begin
        so_d = sh_q[7];
        sh_d = {sh_q[6:0], 1'b0};
      end
    end
    // Released while paused or deselected
    so_oe_d = drive_d & hold_n_s & ~cs_n_s;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q                 <= spi_fram_pkg::ST_IDLE;
      // Matches the synchroniser's reset level so no false edge follows reset
      sck_prev_q           <= 1'b1;
      cnt_q                <= 4'h0;
      in_q                 <= 8'h00;
      cmd_q                <= 8'h00;
      addr_q               <= `ADDR_FIRST;
      wel_q                <= 1'b0;
      nv_q                 <= `NV_RESET;
      rdbuf_q              <= 8'h00;
      sh_q                 <= 8'h00;
      drive_q              <= 1'b0;
      rd_wait_q            <= 1'b0;
      so                   <= 1'b0;
      so_oe                <= 1'b0;
      mem_addr             <= `ADDR_FIRST;
      mem_wdata            <= 8'h00;
      mem_wr               <= 1'b0;
      mem_rd               <= 1'b0;
      write_protect_status <= 8'h00;
    end else begin
      st_q                 <= st_d;
      sck_prev_q           <= sck_s;
      cnt_q                <= cnt_d;
      in_q                 <= in_d;
      cmd_q                <= cmd_d;
      addr_q               <= addr_d;
      wel_q                <= wel_d;
      nv_q                 <= nv_d;
      rdbuf_q              <= rdbuf_d;
      sh_q                 <= sh_d;
      drive_q              <= drive_d;
      rd_wait_q            <= mem_rd;
      so                   <= so_d;
      so_oe                <= so_oe_d;
      mem_addr             <= mem_addr_d;
      mem_wdata            <= mem_wdata_d;
      mem_wr               <= mem_wr_d;
      mem_rd               <= mem_rd_d;
      write_protect_status <= spi_fram_pkg::status_byte(nv_d, wel_d);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_latch_set_cmd: assert property (
    (st_q == spi_fram_pkg::ST_OPCODE) && byte_done && !end_frame && (byte_in == `OP_LATCH_SET)
    |=> wel_q ##1 write_protect_status[`SR_LATCH])
    else $error("latch not set by set command");

  a_latch_clear_cmd: assert property (
    (st_q == spi_fram_pkg::ST_OPCODE) && byte_done && !end_frame && (byte_in == `OP_LATCH_CLEAR)
    |=> !wel_q ##1 !write_protect_status[`SR_LATCH])
    else $error("latch not cleared by clear command");

  a_latch_reset_clear: assert property (
    @(posedge clk) disable iff (1'b0) srst |=> !wel_q && !mem_wr)
    else $error("latch set after reset");

  a_write_end_clear: assert property (
    end_frame && (cmd_q == `OP_MEM_WRITE) && (st_q == spi_fram_pkg::ST_WR_DATA) |=> !wel_q)
    else $error("latch survived end of memory write");

  a_write_guarded: assert property (
    mem_wr |-> $past(wel_q) && !spi_fram_pkg::blocked($past(nv_q[1:0]), mem_addr))
    else $error("memory write to protected or disabled target");

  a_write_eighth_bit: assert property (
    (st_q == spi_fram_pkg::ST_WR_DATA) && byte_done && !end_frame && wel_q &&
    !spi_fram_pkg::blocked(nv_q[1:0], addr_q)
    |=> mem_wr && (mem_wdata == $past(byte_in)) && (mem_addr == $past(addr_q)))
    else $error("data byte not stored at eighth bit");

  a_addr_wrap: assert property (
    (st_q == spi_fram_pkg::ST_RD_DATA) && byte_done && !end_frame && (addr_q == `ADDR_LAST)
    |=> mem_rd && (mem_addr == `ADDR_LAST) && (addr_q == `ADDR_FIRST))
    else $error("address did not wrap");

  a_status_pin_lock: assert property (
    (st_q == spi_fram_pkg::ST_SR_WR) && byte_done && !end_frame && sr_locked |=> $stable(nv_q) && !wel_q)
    else $error("status changed while pin protected");

  a_output_only_read: assert property (
    so_oe |-> $past(hold_n_s) && ((st_q == spi_fram_pkg::ST_RD_DATA) ||
    (st_q == spi_fram_pkg::ST_SR_RD) || $past(drive_q)))
    else $error("output driven outside read data");

  a_hold_freeze: assert property (
    !hold_n_s && !cs_n_s && (st_q != spi_fram_pkg::ST_IDLE) |=> $stable(cnt_q) && $stable(st_q))
    else $error("state moved while paused");

  a_unknown_ignored: assert property (
    (st_q == spi_fram_pkg::ST_OPCODE) && byte_done && !end_frame && (byte_in[7:3] != 5'h00)
    |=> (st_q == spi_fram_pkg::ST_IGNORE) && $stable(wel_q) && $stable(nv_q))
    else $error("unknown opcode not ignored");

  c_mem_write: cover property (mem_wr ##[1:300] end_frame);
  c_mem_read_two: cover property (mem_rd ##[1:300] mem_rd);
  c_status_write: cover property ((st_q == spi_fram_pkg::ST_SR_WR) && byte_done && wel_q && !sr_locked);
  c_hold_in_read: cover property ((st_q == spi_fram_pkg::ST_RD_DATA) && !hold_n_s);

endmodule : spi_fram_command_slave

// >>> sim/spi_host_model.sv
// Purpose: Host master model driving the serial pins in mode 0 or mode 3
// Assumes: 320 ns serial clock; so_w is the resolved output wire
// Notes:   Read bits are taken late in the high phase, where the output has settled
module spi_host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so_w
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam time HALF = 160ns;
  logic cpol;

  initial begin
    cpol   = 1'b0;
    sck    = 1'b0;
    cs_n   = 1'b1;
    si     = 1'b0;
    hold_n = 1'b1;
  end

  // Mode 3 idles high and falls first, so capture stays on rising edges
  task automatic start(input logic mode3);
    cpol = mode3;
    sck  = mode3;
    #HALF;
    cs_n = 1'b0;
    #HALF;
  endtask : start

  // Hold moves only while the clock is low; the pulses in between must not count
  // Hold falls a little after the clock so the falling edge itself still shifts data
  task automatic pause();
    #(HALF / 2);
    hold_n = 1'b0;
    #HALF;
    repeat (3) begin
      sck = 1'b1;
      si  = ~si;
      #HALF;
      sck = 1'b0;
      #HALF;
    end
    hold_n = 1'b1;
    #HALF;
  endtask : pause

  task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      if (i == hold_at) pause();
      si = tx[i];
      #HALF;
      sck = 1'b1;
      #(HALF - 10ns);
      rx[i] = so_w;
      #10ns;
    end
  endtask : xfer

  // Select rises with the clock at its idle level; data line flips so no stale level lingers
  task automatic stop();
    sck = cpol;
    #HALF;
    cs_n = 1'b1;
    si   = ~si;
    #(2 * HALF);
  endtask : stop
endmodule : spi_host_model

// >>> sim/tb_spi_fram_command_slave.sv
// Purpose: Self-checking bench for the serial memory command slave
// Assumes: Storage answers one clk after a read pulse
// Notes:   Stores and read bytes are checked against queued notes
module tb_spi_fram_command_slave;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, srst, sck, cs_n, si, hold_n, wp_n, so, so_oe, mem_wr, mem_rd;
  logic [10:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata, status, rx;
  logic [7:0]  store [2048];
  logic [7:0]  shadow [2048];
  logic [18:0] exp_wr [$];
  logic [7:0]  exp_rd [$];
  int          err_count, num_checks;
  event        got;
  wire         so_w = so_oe ? so : 1'bz;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  spi_fram_command_slave i_dut (
    .clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so(so), .so_oe(so_oe), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .write_protect_status(status)
  );

  spi_host_model i_host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_w(so_w));

  always @(posedge clk) begin
    if (mem_wr) store[mem_addr] <= mem_wdata;
    if (mem_rd) mem_rdata <= store[mem_addr];
  end

  task automatic check(input string what, input logic [18:0] exp, input logic [18:0] seen);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  always @(posedge clk) begin
    if (mem_wr === 1'b1) begin
      if (exp_wr.size() == 0) check("stray store", 19'hX, {mem_addr, mem_wdata});
      else check("store", exp_wr.pop_front(), {mem_addr, mem_wdata});
    end
  end

  always @(got) check("read byte", {11'h0, exp_rd.pop_front()}, {11'h0, rx});

  // Own reading of the protected ranges, kept apart from the design's
  function automatic logic prot(input logic [1:0] bp, input logic [10:0] a);
    return (bp == 2'h3) || (bp == 2'h2 && a[10]) || (bp == 2'h1 && a[10:9] == 2'h3);
  endfunction : prot

  task automatic put(input logic [7:0] b, input int h = -1);
    logic [7:0] r;
    i_host.xfer(b, h, r);
  endtask : put

  task automatic get(input logic [7:0] e, input int h = -1);
    exp_rd.push_back(e);
    i_host.xfer(8'($urandom), h, rx);
    -> got;
  endtask : get

  task automatic open();
    i_host.start(1'($urandom));
  endtask : open

  task automatic cmd1(input logic [7:0] op);
    open();
    put(op);
    i_host.stop();
  endtask : cmd1

  task automatic addr(input logic [10:0] a);
    put({5'($urandom), a[10:8]});
    put(a[7:0]);
  endtask : addr

  task automatic status_read_cmd(input logic [7:0] e);
    open();
    put(8'h05);
    get(e);
    i_host.stop();
  endtask : status_read_cmd

  task automatic status_write_cmd(input logic [7:0] v);
    cmd1(8'h06);
    open();
    put(8'h01);
    put(v);
    i_host.stop();
  endtask : status_write_cmd

  task automatic mwr(input logic [10:0] a, input int n, input logic en, input logic [1:0] bp, input int h = -1);
    logic [7:0]  d;
    logic [10:0] ad;
    if (en) cmd1(8'h06);
    open();
    put(8'h02);
    addr(a);
    for (int k = 0; k < n; k++) begin
      d  = 8'($urandom);
      ad = 11'(a + k);
      if (en && !prot(bp, ad)) begin
        exp_wr.push_back({ad, d});
        shadow[ad] = d;
      end
      put(d, (k == 0) ? h : -1);
    end
    i_host.stop();
  endtask : mwr

  task automatic mrd(input logic [10:0] a, input int n, input int h = -1);
    open();
    put(8'h03);
    addr(a);
    for (int k = 0; k < n; k++) get(shadow[11'(a + k)], (k == 0) ? h : -1);
    i_host.stop();
  endtask : mrd

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  initial begin
    #3ms;
    err_count++;
    summarize();
  end

  initial begin
    logic [1:0] bp;
    srst       = 1'b1;
    wp_n       = 1'b1;
    mem_rdata  = 8'h00;
    err_count  = 0;
    num_checks = 0;
    for (int i = 0; i < 2048; i++) begin
      store[i]  = 8'(i * 7);
      shadow[i] = 8'(i * 7);
    end
    void'($urandom(32'hB3C5D681));
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("status after reset", 19'h0, {11'h0, status});
    mwr(11'h123, 1, 1'b0, 2'h0);
    status_read_cmd(8'h00);
    cmd1(8'h06);
    status_read_cmd(8'h02);
    cmd1(8'h04);
    status_read_cmd(8'h00);
    mwr(11'h7FE, 3, 1'b1, 2'h0, 2);
    status_read_cmd(8'h00);
    mrd(11'h7FE, 3);
    mrd(11'h400, 2, 4);
    status_write_cmd(8'hFF);
    check("status port", {11'h0, 8'h8C}, {11'h0, status});
    for (int b = 0; b < 4; b++) begin
      bp = 2'(b + 1);
      status_write_cmd({4'h0, bp, 2'h0});
      status_read_cmd({4'h0, bp, 2'h0});
      mwr((bp == 2'h1) ? 11'h5FF : (bp == 2'h2) ? 11'h3FF : 11'h7FF, 2, 1'b1, bp);
    end
    status_write_cmd(8'h88);
    wp_n = 1'b0;
    status_write_cmd(8'h00);
    status_read_cmd(8'h88);
    mwr(11'h3FF, 2, 1'b1, 2'h2);
    wp_n = 1'b1;
    status_write_cmd(8'h00);
    status_read_cmd(8'h00);
    cmd1(8'h06);
    open();
    put(8'hA5);
    put(8'h02);
    addr(11'h010);
    put(8'h77);
    i_host.stop();
    status_read_cmd(8'h02);
    cmd1(8'h04);
    open();
    put(8'h06);
    put(8'h02);
    addr(11'h020);
    put(8'h33);
    i_host.stop();
    status_read_cmd(8'h02);
    cmd1(8'h04);
    repeat (10) @(posedge clk);
    #1;
    check("pending stores", 19'h0, 19'(exp_wr.size()));
    summarize();
  end
endmodule : tb_spi_fram_command_slave
